//--- rtl/madc_pkg.sv
// package: constants, states and state record of the acquisition control block
package madc_pkg;

    // timing at the 50 MHz system clock
    localparam int CLK_NS          = 20;
    localparam int ACQ_NS          = 9000;
    localparam int ACQ_CYC         = (ACQ_NS + CLK_NS - 1) / CLK_NS;
    localparam int EXTRA_NS_PER_K  = 1000;
    localparam int EXTRA_CYC_PER_K = (EXTRA_NS_PER_K + CLK_NS - 1) / CLK_NS;
    localparam int CONV_CLK_NS     = 500;
    localparam int DIV_CYC         = CONV_CLK_NS / CLK_NS;
    localparam int CONV_MAX_NS     = 10000;
    localparam int CONV_MAX_CYC    = CONV_MAX_NS / CLK_NS;
    localparam int RES_BITS        = 12;

    // register offsets, byte addresses
    localparam logic [3:0] OFS_STATUS = 4'h0;
    localparam logic [3:0] OFS_CLEAR  = 4'h4;
    localparam logic [3:0] OFS_ENABLE = 4'h8;
    localparam logic [3:0] OFS_RESULT = 4'hc;

    // event bit positions
    localparam int EV_DONE   = 0;
    localparam int EV_IGNORE = 1;

    // values after reset, then the SAR first trial bit and last step
    localparam logic [3:0]  CHAN_RST = 4'h0;
    localparam logic [1:0]  IEN_RST  = 2'h0;
    localparam logic [11:0] MSB_MASK = 12'h800;
    localparam logic [3:0]  LAST_STEP = 4'hb;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_ACQ  = 3'b010,
        ST_CONV = 3'b100
    } madc_state_t;

    typedef struct packed {
        madc_state_t state;
        logic        trig_prev;
        logic        selfstart;
        logic        start_pulse;
        logic [3:0]  chan;
        logic [11:0] timer;
        logic [4:0]  div;
        logic [3:0]  step;
        logic [11:0] held;
        logic [11:0] sar;
        logic [11:0] result;
        logic [1:0]  sts;
        logic [1:0]  ien;
        logic [31:0] rdata;
    } madc_regs_t;

endpackage : madc_pkg

//--- rtl/madc_ctrl.sv
// multiplexed acquisition and conversion control, with status registers
//
// How it works
// - falling trigger edge starts acquisition then conversion; host makes the edge.
// - mode input low loads the external channel address at the trigger edge.
// - mode input high is sequential; self-starts once after reset, no trigger needed.
// - clear input low makes next trigger select channel zero, overriding mode.
// - multiplexer enable low disconnects all channels; high routes addressed channel.
// - random address input is natural binary weighted 8, 4, 2, 1.
// - channel register always shown on four address outputs, natural binary.
// - each result group drives only while its own low enable is low.
// - acquisition lasts 9 us by default, longer by the timing pin setting.
// - timer expiry enters hold, gates conversion clock, pulses start, raises status.
// - conversion ends within 10 us, then sample-hold returns to acquiring.
// - status falls as the 12-bit result becomes valid at the outputs.
`timescale 1ns/1ps
`default_nettype none

module madc_ctrl (
    input  wire logic        clk_sys,
    input  wire logic        rstn,
    input  wire logic        trig_n,
    input  wire logic        addr_mode,
    input  wire logic        chan_clear_n,
    input  wire logic        mux_en,
    input  wire logic        channel_sel_in_bit3,
    input  wire logic        channel_sel_in_bit2,
    input  wire logic        channel_sel_in_bit1,
    input  wire logic        channel_sel_in_bit0,
    input  wire logic [5:0]  acquisition_timer_pin,
    input  wire logic [11:0] sh_sample,
    input  wire logic [2:0]  grp_en_n,
    input  wire logic [3:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic [31:0]      reg_rdata,
    output logic             irq,
    output logic [3:0]       chan_out,
    output logic             mux_on,
    output logic [3:0]       mux_chan,
    output logic             sh_hold,
    output logic             conv_clk_en,
    output logic             start_conv,
    output logic             eoc,
    output logic [11:0]      data_o,
    output logic [11:0]      data_oe
);

    madc_pkg::madc_regs_t r;
    madc_pkg::madc_regs_t n;
    logic                 fall;
    logic                 start;
    logic [1:0]           ev;
    logic [1:0]           clr;
    logic [11:0]          trial;
    logic [3:0]           sel_in;
    logic [11:0]          acq_load;

    assign sel_in   = {channel_sel_in_bit3, channel_sel_in_bit2,
                       channel_sel_in_bit1, channel_sel_in_bit0};
    assign fall     = r.trig_prev & ~trig_n;
    // self-start after reset
    // self-start only when idle in sequential mode and never yet started
    assign start    = (r.state == madc_pkg::ST_IDLE) && (fall || (r.selfstart && addr_mode));
    assign trial    = r.sar | (madc_pkg::MSB_MASK >> r.step);
    // default plus extension
    // each timing-pin step adds one microsecond, like 1k of delay resistor
    assign acq_load = 12'(madc_pkg::ACQ_CYC - 1)
                    + 12'(int'(acquisition_timer_pin) * madc_pkg::EXTRA_CYC_PER_K);
    assign clr      = (reg_wr && reg_addr == madc_pkg::OFS_CLEAR) ? reg_wdata[1:0] : 2'h0;

    always_comb
    begin
        n             = r;
        ev            = 2'h0;
        n.start_pulse = 1'b0;
        n.trig_prev   = trig_n;
        n.rdata       = 32'h0;
        unique case (r.state)
            madc_pkg::ST_IDLE:
            begin
                if (start)
                begin
                    n.state     = madc_pkg::ST_ACQ;
                    n.selfstart = 1'b0;
                    n.timer     = acq_load;
                    if (fall)
                    begin
                        if (!chan_clear_n)
                            n.chan = madc_pkg::CHAN_RST;
                        else if (!addr_mode)
                            n.chan = sel_in;
                        else
                            n.chan = r.chan + 4'h1;
                    end
                end
            end
            madc_pkg::ST_ACQ:
            begin
                if (fall)
                    ev[madc_pkg::EV_IGNORE] = 1'b1;
                // timer expiry enters hold and starts conversion
                if (r.timer == 12'h0)
                begin
                    n.state       = madc_pkg::ST_CONV;
                    n.start_pulse = 1'b1;
                    n.held        = sh_sample;
                    n.sar         = 12'h0;
                    n.step        = 4'h0;
                    n.div         = 5'h0;
                end
                else
                    n.timer = r.timer - 12'h1;
            end
            madc_pkg::ST_CONV:
            begin
                if (fall)
                    ev[madc_pkg::EV_IGNORE] = 1'b1;
                // one successive-approximation decision per conversion clock
                if (r.div == 5'(madc_pkg::DIV_CYC - 1))
                begin
                    n.div = 5'h0;
                    n.sar = (r.held >= trial) ? trial : r.sar;
                    if (r.step == madc_pkg::LAST_STEP)
                    begin
                        n.result             = n.sar;
                        n.state              = madc_pkg::ST_IDLE;
                        ev[madc_pkg::EV_DONE] = 1'b1;
                    end
                    else
                        n.step = r.step + 4'h1;
                end
                else
                    n.div = r.div + 5'h1;
            end
        endcase
        // set wins over a clear in the same cycle
        n.sts = (r.sts & ~clr) | ev;
        if (reg_wr && reg_addr == madc_pkg::OFS_ENABLE)
            n.ien = reg_wdata[1:0];
        if (reg_rd)
        begin
            case (reg_addr)
                madc_pkg::OFS_STATUS: n.rdata = {30'h0, r.sts};
                madc_pkg::OFS_ENABLE: n.rdata = {30'h0, r.ien};
                madc_pkg::OFS_RESULT: n.rdata = {15'h0, eoc, r.chan, r.result};
                default:              n.rdata = 32'h0;
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            r           <= '0;
            r.state     <= madc_pkg::ST_IDLE;
            r.trig_prev <= 1'b1;
            r.selfstart <= 1'b1;
            r.chan      <= madc_pkg::CHAN_RST;
            r.ien       <= madc_pkg::IEN_RST;
        end
        else
            r <= n;
    end

    assign chan_out    = r.chan;
    assign mux_chan    = r.chan;
    assign mux_on      = mux_en;
    assign eoc         = (r.state == madc_pkg::ST_CONV);
    assign sh_hold     = eoc;
    assign conv_clk_en = eoc;
    assign start_conv  = r.start_pulse;
    // bit 1 is data_o[11], bit 12 is data_o[0]
    assign data_o      = r.result;
    assign reg_rdata   = r.rdata;
    assign irq         = |(r.sts & r.ien);

    // group g drives data_o[4g+3:4g]; grp_en_n[2] covers bits 1-4
    for (genvar g = 0; g < 3; g++)
    begin : g_grp
        assign data_oe[4*g +: 4] = {4{~grp_en_n[g]}};
    end

    // checks
    localparam int A_ACQ  = madc_pkg::ACQ_CYC + 1;
    localparam int A_CONV = madc_pkg::CONV_MAX_CYC;
    localparam int A_SPAN = madc_pkg::RES_BITS * madc_pkg::DIV_CYC;

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rstn);

    sequence s_trig_idle;
        fall && r.state == madc_pkg::ST_IDLE;
    endsequence

    sequence s_expiry;
        r.state == madc_pkg::ST_ACQ && r.timer == 12'h0;
    endsequence

    sequence s_conv_begin;
        $rose(eoc) && start_conv;
    endsequence

    a_random_load: assert property (s_trig_idle and (chan_clear_n && !addr_mode) |=> chan_out == $past(sel_in))
        else $error("random address not loaded");

    a_clear_prio: assert property (s_trig_idle and !chan_clear_n |=> chan_out == 4'h0)
        else $error("clear did not select channel zero");

    a_seq_step: assert property (s_trig_idle and (chan_clear_n && addr_mode) |=> chan_out == $past(chan_out) + 4'h1)
        else $error("sequential step wrong");

    a_acq_time: assert property (start && acquisition_timer_pin == 6'h0 |-> ##[A_ACQ:A_ACQ] $rose(eoc))
        else $error("acquisition time wrong");

    a_hold_start: assert property (s_expiry |=> start_conv && eoc && sh_hold && conv_clk_en ##1 !start_conv)
        else $error("hold entry sequence wrong");

    a_conv_bound: assert property ($rose(eoc) |-> ##[1:A_CONV] $fell(eoc))
        else $error("conversion too long");

    a_eoc_result: assert property ($fell(eoc) |-> r.sts[madc_pkg::EV_DONE] && $changed(r.state))
        else $error("done not flagged at status fall");

    a_mux_off: assert property (!mux_en |-> !mux_on)
        else $error("multiplexer not disconnected");

    a_grp_float: assert property (grp_en_n[2] |-> data_oe[11:8] == 4'h0 && data_o == r.result)
        else $error("disabled group still driving");

    a_busy_ignore: assert property (fall && r.state != madc_pkg::ST_IDLE |=> $stable(chan_out) && r.sts[madc_pkg::EV_IGNORE])
        else $error("busy trigger not ignored");

    a_trig_start: assert property (s_trig_idle |=> r.state == madc_pkg::ST_ACQ)
        else $error("trigger edge did not start acquisition");

    a_idle_wait: assert property (r.state == madc_pkg::ST_IDLE && !start |=> r.state == madc_pkg::ST_IDLE)
        else $error("cycle started without a trigger");

    a_ignore_sticky: assert property (r.sts[madc_pkg::EV_IGNORE] && !clr[madc_pkg::EV_IGNORE]
                                      |=> r.sts[madc_pkg::EV_IGNORE])
        else $error("ignored trigger flag lost");

    a_self_start: assert property (r.state == madc_pkg::ST_IDLE && r.selfstart && addr_mode && !fall
                                   |=> r.state == madc_pkg::ST_ACQ && $stable(chan_out))
        else $error("self-start did not begin acquisition");

    a_selfstart_once: assert property (r.state != madc_pkg::ST_IDLE |-> !r.selfstart)
        else $error("self-start still armed while busy");

    a_seq_wrap: assert property (s_trig_idle and (chan_clear_n && addr_mode && chan_out == 4'hf)
                                 |=> chan_out == 4'h0)
        else $error("sequential address did not wrap");

    a_chan_steady: assert property (r.state != madc_pkg::ST_IDLE |=> $stable(chan_out))
        else $error("channel changed while busy");

    a_acq_hold: assert property (r.state == madc_pkg::ST_ACQ && r.timer != 12'h0
                                 |=> r.state == madc_pkg::ST_ACQ && !eoc)
        else $error("acquisition ended early");

    a_mux_route: assert property (mux_en |-> mux_on && mux_chan == chan_out)
        else $error("multiplexer not routing addressed channel");

    a_grp_mid: assert property (grp_en_n[1] |-> data_oe[7:4] == 4'h0)
        else $error("middle group still driving");

    a_grp_low: assert property (grp_en_n[0] |-> data_oe[3:0] == 4'h0)
        else $error("low group still driving");

    a_grp_drive: assert property (grp_en_n == 3'h0 |-> data_oe == 12'hfff)
        else $error("enabled groups not driving");

    a_start_width: assert property (start_conv |=> !start_conv)
        else $error("start pulse longer than one cycle");

    a_start_first: assert property (start_conv |-> $rose(eoc) && sh_hold && conv_clk_en)
        else $error("start pulse outside first hold cycle");

    a_conv_exact: assert property (s_conv_begin |-> ##A_SPAN $fell(eoc))
        else $error("conversion length wrong");

    a_back_idle: assert property ($fell(eoc) |-> r.state == madc_pkg::ST_IDLE && !start_conv)
        else $error("not back to acquiring after conversion");

    a_result_value: assert property ($fell(eoc) |-> data_o == r.held)
        else $error("result differs from held sample");

    a_result_stable: assert property (!$fell(eoc) |-> $stable(data_o))
        else $error("result changed outside completion");

    a_done_sticky: assert property (r.sts[madc_pkg::EV_DONE] && !clr[madc_pkg::EV_DONE]
                                    |=> r.sts[madc_pkg::EV_DONE])
        else $error("done flag lost without clear");

endmodule : madc_ctrl

`default_nettype wire

//--- test/madc_host.sv
// host model that makes the conversion trigger
`timescale 1ns/1ps
`default_nettype none
module madc_host (
    input  wire logic clk_sys,
    input  wire logic rstn,
    input  wire logic go,
    output logic      trig_n
);
    always_ff @(posedge clk_sys or negedge rstn)
        if (!rstn)
            trig_n <= 1'b1;
        else
            trig_n <= ~go;
endmodule : madc_host
`default_nettype wire

//--- test/tb_top.sv
// self-checking bench for the acquisition control block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic        clk_sys = '0, rstn = '0, go = '0, addr_mode = '1, chan_clear_n = '1, mux_en = '1;
    logic        reg_wr = '0, reg_rd = '0, eoc_prev = '0;
    logic [3:0]  sel = '0, reg_addr = '0, c, last_c;
    logic [5:0]  pin = '0;
    logic [11:0] sh_sample = '0, last_s;
    logic [2:0]  grp_en_n = '0;
    logic [31:0] reg_wdata = '0;
    logic [11:0] exp_q[$];
    integer      seed = 32'hb1055d9e;
    int          n_fail = 0, checks = 0;
    wire logic        trig_n, irq, mux_on, sh_hold, conv_clk_en, start_conv, eoc;
    wire logic [31:0] reg_rdata;
    wire logic [3:0]  chan_out, mux_chan;
    wire logic [11:0] data_o, data_oe;

    madc_host madc_host_inst (.clk_sys(clk_sys), .rstn(rstn), .go(go), .trig_n(trig_n));
    madc_ctrl madc_ctrl_inst (
        .clk_sys(clk_sys), .rstn(rstn), .trig_n(trig_n), .addr_mode(addr_mode),
        .chan_clear_n(chan_clear_n), .mux_en(mux_en), .channel_sel_in_bit3(sel[3]),
        .channel_sel_in_bit2(sel[2]), .channel_sel_in_bit1(sel[1]), .channel_sel_in_bit0(sel[0]),
        .acquisition_timer_pin(pin), .sh_sample(sh_sample), .grp_en_n(grp_en_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq),
        .chan_out(chan_out), .mux_on(mux_on), .mux_chan(mux_chan), .sh_hold(sh_hold),
        .conv_clk_en(conv_clk_en), .start_conv(start_conv), .eoc(eoc), .data_o(data_o), .data_oe(data_oe));

    initial forever #10 clk_sys = ~clk_sys;

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic finish_test;
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : finish_test

    // results on data_o are compared where status falls
    always @(posedge clk_sys)
    begin
        eoc_prev <= eoc;
        if (eoc_prev === 1'b1 && eoc === 1'b0)
            check("result", data_o, exp_q.size() != 0 ? 32'(exp_q.pop_front()) : 32'h1000);
    end

    task automatic wait_eoc(input logic v, inout int n);
        while (eoc !== v && n < 2000)
        begin
            @(posedge clk_sys);
            #1;
            n++;
        end
    endtask : wait_eoc

    // m: 0 self-started, 1 triggered, 2 triggered plus a refused trigger
    task automatic conv(input logic [3:0] code, ec, input logic [5:0] p, input int m);
        int n;
        logic [11:0] s;
        s = 12'($random(seed));
        exp_q.push_back(s);
        last_s = s;
        last_c = ec;
        n = 0;
        @(posedge clk_sys);
        sel <= code;
        pin <= p;
        sh_sample <= s;
        go <= (m != 0);
        @(posedge clk_sys);
        go <= 1'b0;
        @(posedge clk_sys);
        wait_eoc(1'b1, n);
        if (m != 0)
            check("acq", n, madc_pkg::ACQ_CYC + p * madc_pkg::EXTRA_CYC_PER_K);
        check("hold", {start_conv, sh_hold, conv_clk_en}, 3'b111);
        check("chan", {chan_out, mux_chan}, {ec, ec});
        go <= (m == 2);
        @(posedge clk_sys);
        go <= 1'b0;
        #1;
        check("start", start_conv, 1'b0);
        n = 1;
        wait_eoc(1'b0, n);
        check("conv", n, 12 * madc_pkg::DIV_CYC);
        check("chan kept", chan_out, ec);
        @(posedge clk_sys);
    endtask : conv

    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [3:0] a, input logic [31:0] e, input string what);
        @(posedge clk_sys);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1;
        check(what, reg_rdata, e);
    endtask : rd

    task automatic irq_is(input logic e);
        @(posedge clk_sys);
        #1;
        check("irq", irq, e);
    endtask : irq_is

    initial
    begin
        repeat (4) @(posedge clk_sys);
        rstn <= 1'b1;
        conv(4'h0, 4'h0, 6'h00, 0);
        addr_mode <= 1'b0;
        for (int i = 0; i < 3; i++)
        begin
            c = 4'($random(seed));
            conv(c, c, 6'(i), 1);
        end
        conv(4'hf, 4'hf, 6'h00, 2);
        addr_mode <= 1'b1;
        conv(4'h5, 4'h0, 6'h00, 1);
        conv(4'h5, 4'h1, 6'h00, 1);
        $display("test addressing done");
        chan_clear_n <= 1'b0;
        conv(4'h9, 4'h0, 6'h00, 1);
        addr_mode <= 1'b0;
        conv(4'h9, 4'h0, 6'h00, 1);
        chan_clear_n <= 1'b1;
        $display("test clear done");
        rd(madc_pkg::OFS_STATUS, 32'h3, "status");
        irq_is(1'b0);
        wr(madc_pkg::OFS_ENABLE, 32'h1);
        irq_is(1'b1);
        rd(madc_pkg::OFS_ENABLE, 32'h1, "enable");
        rd(madc_pkg::OFS_RESULT, {15'h0, 1'b0, last_c, last_s}, "result");
        wr(madc_pkg::OFS_CLEAR, 32'h1);
        irq_is(1'b0);
        rd(madc_pkg::OFS_STATUS, 32'h2, "status");
        wr(madc_pkg::OFS_CLEAR, 32'h2);
        rd(madc_pkg::OFS_STATUS, 32'h0, "status");
        rd(4'h2, 32'h0, "unmapped");
        rd(madc_pkg::OFS_CLEAR, 32'h0, "clear");
        $display("test registers done");
        for (int g = 0; g < 8; g++)
        begin
            @(posedge clk_sys);
            grp_en_n <= 3'(g);
            mux_en <= g[0];
            #1;
            check("oe", data_oe, {{4{~grp_en_n[2]}}, {4{~grp_en_n[1]}}, {4{~grp_en_n[0]}}});
            check("mux", mux_on, mux_en);
        end
        $display("test enables done");
        finish_test();
    end

    initial
    begin
        repeat (20000) @(posedge clk_sys);
        n_fail++;
        finish_test();
    end
endmodule : tb_top
`default_nettype wire
